// ==== logic/ndsr_pkg.sv ====
package ndsr_pkg;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_STATUS_ADDR = 8'h78;
  localparam logic [7:0] CMD_READ_MODE   = 8'h00;
  localparam logic [7:0] CMD_RESET       = 8'hFF;
  localparam int         BIT_WP          = 7;
  localparam int         BIT_RDY         = 6;
  localparam int         BIT_ARRAY_READY        = 5;
  localparam int         BIT_PRIOR_OP_ERROR       = 1;
  localparam int         BIT_FAIL        = 0;
  localparam int         NUM_PLANES      = 2;
  localparam int         ROW_CYCLES      = 3;
  localparam int         PLANE_ROW_BIT   = 7;
  localparam int         DIE_ROW_BIT     = 7;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [1:0] ADDR_CNT_RESET  = 2'h0;
  typedef enum logic [1:0] {
    NDSR_IDLE   = 2'b00,
    NDSR_ADDR   = 2'b01,
    NDSR_STATUS = 2'b11,
    NDSR_OTHER  = 2'b10
  } ndsr_mode_t;
endpackage

// ==== logic/ndsr_plane_flags.sv ====
`timescale 1ns/1ps
module ndsr_plane_flags (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_done,
  input  wire logic i_fail,
  input  wire logic i_is_prog,
  output logic      o_prior_op_error,
  output logic      o_last_fail
);
  logic prior_ff;
  logic last_ff;
  logic nxt_prior;
  logic nxt_last;

  always_comb begin
    nxt_prior = prior_ff;
    nxt_last  = last_ff;
    if (i_done) begin
      // Last result shifts into previous slot only for program series
      if (i_is_prog) begin
        nxt_prior = last_ff;
      end
      nxt_last = i_fail;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prior_ff <= 1'b0;
      last_ff  <= 1'b0;
    end else begin
      prior_ff <= nxt_prior;
      last_ff  <= nxt_last;
    end
  end

  assign o_prior_op_error = prior_ff;
  assign o_last_fail      = last_ff;
endmodule

// ==== logic/ndsr_die_status.sv ====
`timescale 1ns/1ps
module ndsr_die_status (
  input  wire logic                         I_SYS_CLK,
  input  wire logic                         I_SYS_RST,
  input  wire logic                         I_CMD_VALID,
  input  wire logic [7:0]                   I_CMD,
  input  wire logic                         I_ADDR_VALID,
  input  wire logic [7:0]                   I_ADDR,
  input  wire logic                         I_DATA_REQ,
  input  wire logic                         I_WP_N,
  input  wire logic                         I_OTP_MODE,
  input  wire logic                         I_DIE_ID,
  input  wire logic                         I_DIE_READY,
  input  wire logic [ndsr_pkg::NUM_PLANES-1:0] I_PLANE_BUSY,
  input  wire logic [ndsr_pkg::NUM_PLANES-1:0] I_PLANE_ACTIVE,
  input  wire logic [ndsr_pkg::NUM_PLANES-1:0] I_OP_DONE,
  input  wire logic [ndsr_pkg::NUM_PLANES-1:0] I_OP_FAIL,
  input  wire logic                         I_OP_IS_PROG,
  output logic [7:0]                        O_DQ,
  output logic                              O_DQ_OE,
  output logic                              O_DIE_SELECTED,
  output logic                              O_STATUS_MODE,
  output logic [7:0]                        O_DIE_STATUS_BYTE
);
  logic                        wp_meta_ff;
  logic                        wp_sync_ff;
  ndsr_pkg::ndsr_mode_t        mode_ff;
  ndsr_pkg::ndsr_mode_t        nxt_mode;
  logic [1:0]                  addr_cnt_ff;
  logic [1:0]                  nxt_addr_cnt;
  logic                        plane_sel_ff;
  logic                        nxt_plane_sel;
  logic                        addressed_ff;
  logic                        nxt_addressed;
  logic                        selected_ff;
  logic                        nxt_selected;
  logic [7:0]                  status_ff;
  logic [7:0]                  nxt_status;
  logic [7:0]                  dq_ff;
  logic [7:0]                  nxt_dq;
  logic                        oe_ff;
  logic                        nxt_oe;
  logic                        status_mode_ff;
  logic                        nxt_status_mode;
  logic                        nxt_wp_meta;
  logic                        nxt_wp_sync;
  logic [ndsr_pkg::NUM_PLANES-1:0] prior_err;
  logic [ndsr_pkg::NUM_PLANES-1:0] last_fail;

  genvar gp;
  generate
    for (gp = 0; gp < ndsr_pkg::NUM_PLANES; gp++) begin : g_plane
      ndsr_plane_flags u_flags (
        .i_clk            (I_SYS_CLK),
        .i_rst            (I_SYS_RST),
        .i_done           (I_OP_DONE[gp]),
        .i_fail           (I_OP_FAIL[gp]),
        .i_is_prog        (I_OP_IS_PROG),
        .o_prior_op_error (prior_err[gp]),
        .o_last_fail      (last_fail[gp])
      );
    end
  endgenerate

  // Pin comes from outside the clock domain; only the second stage feeds logic
  always_comb begin
    nxt_wp_meta = I_WP_N;
    nxt_wp_sync = wp_meta_ff;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      wp_meta_ff <= 1'b0;
      wp_sync_ff <= 1'b0;
    end else begin
      wp_meta_ff <= nxt_wp_meta;
      wp_sync_ff <= nxt_wp_sync;
    end
  end

  // Command decode; a command cycle always restarts the row count
  always_comb begin
    nxt_mode      = mode_ff;
    nxt_addr_cnt  = addr_cnt_ff;
    nxt_plane_sel = plane_sel_ff;
    nxt_addressed = addressed_ff;
    nxt_selected  = selected_ff;
    if (I_CMD_VALID) begin
      nxt_addr_cnt = ndsr_pkg::ADDR_CNT_RESET;
      case (I_CMD)
        ndsr_pkg::CMD_STATUS: begin
          // Plain status: only the last-selected die answers, busy or not
          nxt_mode      = ndsr_pkg::NDSR_STATUS;
          nxt_addressed = 1'b0;
        end
        ndsr_pkg::CMD_STATUS_ADDR: begin
          // Accepted regardless of busy; OTP mode blocks it
          if (!I_OTP_MODE) begin
            nxt_mode = ndsr_pkg::NDSR_ADDR;
          end else begin
            nxt_mode = ndsr_pkg::NDSR_OTHER;
          end
        end
        default: begin
          nxt_mode = ndsr_pkg::NDSR_OTHER;
        end
      endcase
    end else begin
      case (mode_ff)
        ndsr_pkg::NDSR_ADDR: begin
          // Die bit comes last, so selection waits for every row cycle
          if (I_ADDR_VALID) begin
            nxt_addr_cnt = addr_cnt_ff + 2'h1;
            if (addr_cnt_ff == ndsr_pkg::ADDR_CNT_RESET) begin
              nxt_plane_sel = I_ADDR[ndsr_pkg::PLANE_ROW_BIT];
            end
            if (addr_cnt_ff == 2'(ndsr_pkg::ROW_CYCLES - 1)) begin
              nxt_selected  = (I_ADDR[ndsr_pkg::DIE_ROW_BIT] == I_DIE_ID);
              nxt_addressed = 1'b1;
              nxt_mode      = ndsr_pkg::NDSR_STATUS;
            end
          end
        end
        ndsr_pkg::NDSR_IDLE,
        ndsr_pkg::NDSR_STATUS,
        ndsr_pkg::NDSR_OTHER: begin
          // Stray address cycles belong to other commands
          nxt_addr_cnt = addr_cnt_ff;
        end
        default: begin
          nxt_mode = ndsr_pkg::NDSR_IDLE;
        end
      endcase
    end
    // Registered copy keeps the status-mode output glitch free
    nxt_status_mode = (nxt_mode == ndsr_pkg::NDSR_STATUS);
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      mode_ff        <= ndsr_pkg::NDSR_IDLE;
      addr_cnt_ff    <= ndsr_pkg::ADDR_CNT_RESET;
      plane_sel_ff   <= 1'b0;
      addressed_ff   <= 1'b0;
      // A lone die must answer plain status before any addressed command
      selected_ff    <= 1'b1;
      status_mode_ff <= 1'b0;
    end else begin
      mode_ff        <= nxt_mode;
      addr_cnt_ff    <= nxt_addr_cnt;
      plane_sel_ff   <= nxt_plane_sel;
      addressed_ff   <= nxt_addressed;
      selected_ff    <= nxt_selected;
      status_mode_ff <= nxt_status_mode;
    end
  end

  // Status byte assembly, refreshed every cycle so busy polling sees changes
  always_comb begin
    nxt_status = ndsr_pkg::STATUS_RESET;
    nxt_status[ndsr_pkg::BIT_WP]   = I_OTP_MODE ? 1'b0 : wp_sync_ff;
    nxt_status[ndsr_pkg::BIT_RDY]  = I_DIE_READY;
    nxt_status[ndsr_pkg::BIT_ARRAY_READY] = ~|I_PLANE_BUSY;
    if (addressed_ff) begin
      nxt_status[ndsr_pkg::BIT_PRIOR_OP_ERROR] = prior_err[plane_sel_ff];
      nxt_status[ndsr_pkg::BIT_FAIL]  = last_fail[plane_sel_ff];
    end else begin
      // Validity after erase/read left to host interpretation
      nxt_status[ndsr_pkg::BIT_PRIOR_OP_ERROR] = |(prior_err & I_PLANE_ACTIVE);
      nxt_status[ndsr_pkg::BIT_FAIL]  = |(last_fail & I_PLANE_ACTIVE);
    end
  end

  // Data output
  always_comb begin
    nxt_dq = dq_ff;
    nxt_oe = 1'b0;
    if (mode_ff == ndsr_pkg::NDSR_STATUS && selected_ff && I_DATA_REQ) begin
      nxt_dq = nxt_status;
      nxt_oe = 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      status_ff <= ndsr_pkg::STATUS_RESET;
      dq_ff     <= ndsr_pkg::STATUS_RESET;
      oe_ff     <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      dq_ff     <= nxt_dq;
      oe_ff     <= nxt_oe;
    end
  end

  assign O_DQ              = dq_ff;
  assign O_DQ_OE           = oe_ff;
  assign O_DIE_SELECTED    = selected_ff;
  assign O_STATUS_MODE     = status_mode_ff;
  assign O_DIE_STATUS_BYTE = status_ff;
endmodule

// ==== tb/ndsr_chk.sv ====
`timescale 1ns/1ps
module ndsr_chk (
  input wire logic       I_SYS_CLK,
  input wire logic       I_SYS_RST,
  input wire logic       I_CMD_VALID,
  input wire logic [7:0] I_CMD,
  input wire logic       I_ADDR_VALID,
  input wire logic [7:0] I_ADDR,
  input wire logic       I_DATA_REQ,
  input wire logic       I_OTP_MODE,
  input wire logic       I_DIE_ID,
  input wire logic       I_DIE_READY,
  input wire logic [1:0] I_PLANE_BUSY,
  input wire logic       O_DQ_OE,
  input wire logic       O_DIE_SELECTED,
  input wire logic       O_STATUS_MODE,
  input wire logic [7:0] O_DIE_STATUS_BYTE
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_cmd78; I_CMD_VALID && I_CMD == ndsr_pkg::CMD_STATUS_ADDR && !I_OTP_MODE; endsequence
  sequence s_rows; I_ADDR_VALID [*3]; endsequence
  property p_rows;
    s_cmd78 ##1 s_rows |=> O_STATUS_MODE && (O_DIE_SELECTED == ($past(I_ADDR[7]) == I_DIE_ID));
  endproperty
  a_rows: assert property (p_rows) else $error("die select after rows wrong");
  property p_plain; I_CMD_VALID && I_CMD == ndsr_pkg::CMD_STATUS |=> O_STATUS_MODE; endproperty
  a_plain: assert property (p_plain) else $error("plain status not taken");
  property p_exit; I_CMD_VALID && I_CMD == ndsr_pkg::CMD_READ_MODE |=> !O_STATUS_MODE; endproperty
  a_exit: assert property (p_exit) else $error("status mode kept");
  property p_oe; I_DATA_REQ && O_STATUS_MODE && O_DIE_SELECTED |=> O_DQ_OE; endproperty
  a_oe: assert property (p_oe) else $error("no status on request");
  property p_quiet; O_DQ_OE |-> $past(I_DATA_REQ) && $past(O_DIE_SELECTED); endproperty
  a_quiet: assert property (p_quiet) else $error("drive without cause");
  property p_array_ready; !$past(I_SYS_RST) |-> O_DIE_STATUS_BYTE[5] == ~|$past(I_PLANE_BUSY); endproperty
  a_array_ready: assert property (p_array_ready) else $error("array ready wrong");
  property p_rdy; !$past(I_SYS_RST) |-> O_DIE_STATUS_BYTE[6] == $past(I_DIE_READY); endproperty
  a_rdy: assert property (p_rdy) else $error("ready bit wrong");
  property p_rsv; O_DIE_STATUS_BYTE[4:2] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind ndsr_die_status ndsr_chk ndsr_chk_inst (.*);

// ==== tb/ndsr_host.sv ====
`timescale 1ns/1ps
module ndsr_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dq,
  input  wire logic       i_dq_oe,
  output logic            o_cmd_valid = 1'b0,
  output logic [7:0]      o_cmd = 8'h00,
  output logic            o_addr_valid = 1'b0,
  output logic [7:0]      o_addr = 8'h00,
  output logic            o_data_req = 1'b0
);
  task automatic cyc(input logic c, input logic a, input logic r, input logic [7:0] v);
    @(posedge i_clk);
    #1;
    o_cmd_valid = c;
    o_addr_valid = a;
    o_data_req = r;
    o_cmd = c ? v : ~o_cmd; // Idle bus shows the last byte inverted, and the last byte again on a second idle cycle
    o_addr = a ? v : ~o_addr;
  endtask
  task automatic stat_addr(input logic pl, input logic die);
    cyc(1'b1, 1'b0, 1'b0, ndsr_pkg::CMD_STATUS_ADDR);
    cyc(1'b0, 1'b1, 1'b0, {pl, 7'h00});
    cyc(1'b0, 1'b1, 1'b0, 8'h00);
    cyc(1'b0, 1'b1, 1'b0, {die, 7'h00});
  endtask
  task automatic rd(output logic oe, output logic [7:0] dq);
    cyc(1'b0, 1'b0, 1'b1, 8'h00);
    cyc(1'b0, 1'b0, 1'b0, 8'h00);
    oe = i_dq_oe;
    dq = i_dq;
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic       I_SYS_CLK = 1'b0;
  logic       I_SYS_RST = 1'b1;
  logic       I_WP_N = 1'b1;
  logic       I_OTP_MODE = 1'b0;
  logic       I_DIE_ID = 1'b0;
  logic       I_DIE_READY = 1'b1;
  logic       I_OP_IS_PROG = 1'b0;
  logic [1:0] I_PLANE_BUSY = 2'h0;
  logic [1:0] I_PLANE_ACTIVE = 2'h3;
  logic [1:0] I_OP_DONE = 2'h0;
  logic [1:0] I_OP_FAIL = 2'h0;
  logic       I_CMD_VALID, I_ADDR_VALID, I_DATA_REQ, O_DQ_OE, O_DIE_SELECTED, O_STATUS_MODE, oe;
  logic [7:0] I_CMD, I_ADDR, O_DQ, O_DIE_STATUS_BYTE, dq;
  int         bad_count = 0;
  int         num_checks = 0;
  ndsr_die_status ndsr_die_status_inst (.*);
  ndsr_host ndsr_host_inst (.i_clk(I_SYS_CLK), .i_dq(O_DQ), .i_dq_oe(O_DQ_OE), .o_cmd_valid(I_CMD_VALID),
    .o_cmd(I_CMD), .o_addr_valid(I_ADDR_VALID), .o_addr(I_ADDR), .o_data_req(I_DATA_REQ));
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  task automatic report_and_stop();
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Data masked while not driving: a floating bus has no value
  task automatic look(input logic [8:0] exp);
    ndsr_host_inst.rd(oe, dq);
    num_checks++;
    if ({oe, dq & {8{oe}}} !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, {oe, dq & {8{oe}}}, exp);
    end
  endtask
  task automatic st70(input logic [8:0] exp);
    ndsr_host_inst.cyc(1'b1, 1'b0, 1'b0, ndsr_pkg::CMD_STATUS);
    look(exp);
  endtask
  task automatic st78(input logic pl, input logic die, input logic [8:0] exp);
    ndsr_host_inst.stat_addr(pl, die);
    look(exp);
  endtask
  task automatic op(input logic [1:0] d, input logic [1:0] f, input logic p);
    @(posedge I_SYS_CLK);
    #1;
    I_OP_DONE = d;
    I_OP_FAIL = f;
    I_OP_IS_PROG = p;
    @(posedge I_SYS_CLK);
    #1;
    I_OP_DONE = 2'h0;
  endtask
  task automatic t_ready();
    I_PLANE_BUSY = 2'h2;
    I_DIE_READY = 1'b0;
    st70(9'h180);
    I_PLANE_BUSY = 2'h0;
    I_DIE_READY = 1'b1;
    st70(9'h1E0);
  endtask
  task automatic t_fail();
    op(2'h3, 2'h1, 1'b1);
    st70(9'h1E1);
    op(2'h3, 2'h0, 1'b1);
    st70(9'h1E2);
    st78(1'b0, 1'b0, 9'h1E2);
    st78(1'b1, 1'b0, 9'h1E0);
    op(2'h2, 2'h2, 1'b0);
    I_PLANE_ACTIVE = 2'h1;
    st70(9'h1E2);
    st78(1'b1, 1'b0, 9'h1E1);
  endtask
  task automatic t_die();
    I_DIE_ID = 1'b1;
    I_PLANE_BUSY = 2'h1;
    I_DIE_READY = 1'b0;
    st78(1'b0, 1'b0, 9'h000);
    st78(1'b0, 1'b1, 9'h182);
    I_PLANE_BUSY = 2'h0;
    I_DIE_READY = 1'b1;
  endtask
  task automatic t_mode();
    ndsr_host_inst.cyc(1'b1, 1'b0, 1'b0, ndsr_pkg::CMD_READ_MODE);
    look(9'h000);
    I_OTP_MODE = 1'b1;
    st78(1'b0, 1'b1, 9'h000);
    st70(9'h162);
    I_OTP_MODE = 1'b0;
    I_WP_N = 1'b0;
    st70(9'h162);
    ndsr_host_inst.cyc(1'b1, 1'b0, 1'b0, 8'h06);
    look(9'h000);
  endtask
  initial begin
    repeat (12) @(posedge I_SYS_CLK);
    #1;
    I_SYS_RST = 1'b0;
    t_ready();
    t_fail();
    t_die();
    t_mode();
    report_and_stop();
  end
  initial begin
    #50000;
    bad_count++;
    report_and_stop();
  end
endmodule
